// >>> design/aics_top.sv
// Input channel select, test mode and interface control registers behind AXI4-Lite
// Operation
// - Input selection from control bits three to seven
// - Bit five differential, six/seven select autoscan
// - Plain code picks one single-ended input
// - Differential code picks A or B pair
// - Scan code 01 alternates A plus, A minus
// - Scan code 10 cycles A+, A-, B+
// - Scan code 11 cycles all four inputs
// - Scan diff 01 alternates A plus, B pair
// - Scan diff 10 cycles A+, A-, B pair
// - Two-differential scan alternates A and B pairs
// - Test field bits eight, nine select reference
// - Test mode converts chosen internal reference level
// - Second register holds reset, overflow, trigger, format
// - Sample ready stays inactive during test mode
// - Reset leaves differential count at 00 (pair A)
`timescale 1ns/10ps
`include "aics_defines.svh"
module aics_top (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic CONVERSION_CLOCK_PIN_I,
  input wire logic FILL_LEVEL_REACHED_I,
  input wire logic FIFO_OVERFLOW_I,
  output logic [3:0] CONV_INPUT_O,
  output logic CONV_TRIGGER_O,
  output logic SAMPLE_READY_FLAG_O,
  output logic FIFO_CLEAR_O,
  output logic [9:0] INPUT_CTRL_O,
  output logic [9:0] IFACE_CTRL_O,
  output logic IRQ_O
);
  aics_pkg::aics_top_state_type s_q;
  aics_pkg::aics_top_state_type s_d;
  aics_pkg::aics_input_type seq_input;
  logic pin_fall;
  logic seq_wrap;
  logic seq_reserved;
  logic [1:0] test_sel;
  logic test_active;
  logic wr_fire;
  logic rd_fire;
  logic [2:0] irq_set;

  // ----------------------------------------------------------------
  // Conversion clock pin synchroniser
  // ----------------------------------------------------------------
  // The pin is asynchronous; a conversion starts on its falling edge
  aics_pin_sync #(
    .STAGES(`AICS_SYNC_STAGES)
  ) u_pin_sync (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .pin_i(CONVERSION_CLOCK_PIN_I),
    .level_o(),
    .fall_o(pin_fall)
  );

  // ----------------------------------------------------------------
  // Channel sequencer
  // ----------------------------------------------------------------
  aics_scan_seq u_scan_seq (
    .clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .sel_i(s_q.input_ctrl[`AICS_SEL_MSB:`AICS_SEL_LSB]),
    .restart_i(s_q.restart),
    .advance_i(pin_fall),
    .input_o(seq_input),
    .wrap_o(seq_wrap),
    .reserved_o(seq_reserved)
  );

  // ----------------------------------------------------------------
  // Byte-lane merge helper
  // ----------------------------------------------------------------
  // Ten-bit registers span lanes 0 and 1; other lanes are dropped
  function automatic logic [9:0] merge10(input logic [9:0] old_v,
                                         input logic [31:0] data,
                                         input logic [3:0] strb);
    merge10 = old_v;
    if (strb[0]) begin
      merge10[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge10[9:8] = data[9:8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  assign test_sel = s_q.input_ctrl[`AICS_TEST_MSB:`AICS_TEST_LSB];
  assign test_active = (test_sel != 2'h0);
  assign wr_fire = s_q.aw_hold && s_q.w_hold && !s_q.bvalid;
  assign rd_fire = S_AXI_ARVALID_I && !s_q.rvalid;

  // Interrupt events: reserved code held, FIFO overflow, scan wrap
  always_comb begin
    irq_set = '0;
    irq_set[`AICS_IRQ_RESERVED_BIT] = seq_reserved;
    irq_set[`AICS_IRQ_OVFL_BIT] = FIFO_OVERFLOW_I;
    irq_set[`AICS_IRQ_WRAP_BIT] = seq_wrap;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.fifo_clr = 1'b0;
    s_d.restart = 1'b0;
    s_d.trig = pin_fall;
    s_d.fill_prev = FILL_LEVEL_REACHED_I;

    // Write address and data are captured independently, in any order
    if (S_AXI_AWVALID_I && !s_q.aw_hold) begin
      s_d.aw_hold = 1'b1;
      s_d.aw_addr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && !s_q.w_hold) begin
      s_d.w_hold = 1'b1;
      s_d.w_data = S_AXI_WDATA_I;
      s_d.w_strb = S_AXI_WSTRB_I;
    end

    // Status bits are W1C; set below wins over a same-cycle clear
    if (wr_fire) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `AICS_RESP_OKAY;
      unique case (s_q.aw_addr)
        `AICS_ADDR_INPUT_CTRL: begin
          s_d.input_ctrl = merge10(s_q.input_ctrl, s_q.w_data, s_q.w_strb);
          s_d.restart = 1'b1;
        end
        `AICS_ADDR_IFACE_CTRL: begin
          // Overflow bit reads back only; a written one clears the FIFO
          s_d.iface_ctrl = merge10(s_q.iface_ctrl, s_q.w_data, s_q.w_strb);
          s_d.iface_ctrl[`AICS_IF_OVFL_BIT] = 1'b0;
          s_d.iface_ctrl[`AICS_IF_RESET_BIT] = 1'b0;
          if (s_q.w_strb[0] && s_q.w_data[`AICS_IF_OVFL_BIT]) begin
            s_d.fifo_clr = 1'b1;
          end
          // Soft reset returns both control registers to reset values
          if (s_q.w_strb[0] && s_q.w_data[`AICS_IF_RESET_BIT]) begin
            s_d.input_ctrl = `AICS_INPUT_CTRL_RST;
            s_d.iface_ctrl = `AICS_IFACE_CTRL_RST;
            s_d.fifo_clr = 1'b1;
            s_d.restart = 1'b1;
          end
        end
        `AICS_ADDR_IRQ_STATUS: begin
          if (s_q.w_strb[0]) begin
            s_d.irq_stat = s_q.irq_stat & ~s_q.w_data[2:0];
          end
        end
        `AICS_ADDR_IRQ_MASK: begin
          if (s_q.w_strb[0]) begin
            s_d.irq_mask = s_q.w_data[2:0];
          end
        end
        `AICS_ADDR_SEQ_STATUS: begin
          s_d.bresp = `AICS_RESP_OKAY; // Read-only: write ignored
        end
        default: begin
          s_d.bresp = `AICS_RESP_SLVERR;
        end
      endcase
    end
    if (s_q.bvalid && S_AXI_BREADY_I) begin
      s_d.bvalid = 1'b0;
    end

    // Read answer is registered one cycle after the address is taken
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `AICS_RESP_OKAY;
      s_d.rdata = '0;
      unique case (S_AXI_ARADDR_I)
        `AICS_ADDR_INPUT_CTRL: s_d.rdata[9:0] = s_q.input_ctrl;
        `AICS_ADDR_IFACE_CTRL: begin
          // Reading reports overflow and clears it
          s_d.rdata[9:0] = {s_q.iface_ctrl[9:2], s_q.ovfl, 1'b0};
          s_d.ovfl = 1'b0;
        end
        `AICS_ADDR_IRQ_STATUS: s_d.rdata[2:0] = s_q.irq_stat;
        `AICS_ADDR_IRQ_MASK: s_d.rdata[2:0] = s_q.irq_mask;
        `AICS_ADDR_SEQ_STATUS: s_d.rdata[5:0] = {seq_reserved, test_active, s_q.conv_input};
        default: s_d.rresp = `AICS_RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && S_AXI_RREADY_I) begin
      s_d.rvalid = 1'b0;
    end

    // A new overflow in the clearing read cycle is kept
    if (FIFO_OVERFLOW_I) begin
      s_d.ovfl = 1'b1;
    end
    s_d.irq_stat = s_d.irq_stat | irq_set;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

    // Test field overrides the scan choice with a reference level
    unique case (test_sel)
      2'h0: s_d.conv_input = seq_input;
      2'h1: s_d.conv_input = aics_pkg::AICS_IN_REF_UPPER;
      2'h2: s_d.conv_input = aics_pkg::AICS_IN_REF_MID;
      2'h3: s_d.conv_input = aics_pkg::AICS_IN_REF_LOWER;
    endcase

    // Sample ready: pulse on rising fill level or static level,
    // held off in test mode; polarity applied at the pin
    if (test_active) begin
      s_d.ready = 1'b0;
    end else if (s_q.iface_ctrl[`AICS_IF_PULSE_BIT]) begin
      s_d.ready = FILL_LEVEL_REACHED_I && !s_q.fill_prev;
    end else begin
      s_d.ready = FILL_LEVEL_REACHED_I;
    end
  end

  // ----------------------------------------------------------------
  // Registered state
  // ----------------------------------------------------------------
  // Reset values keep the first pair difference selected
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      s_q <= '0;
      s_q.input_ctrl <= `AICS_INPUT_CTRL_RST;
      s_q.iface_ctrl <= `AICS_IFACE_CTRL_RST;
      s_q.conv_input <= aics_pkg::AICS_IN_DIFF_A;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Ready outputs are combinational so a channel never stalls twice
  assign S_AXI_AWREADY_O = !s_q.aw_hold;
  assign S_AXI_WREADY_O = !s_q.w_hold;
  assign S_AXI_BVALID_O = s_q.bvalid;
  assign S_AXI_BRESP_O = s_q.bresp;
  assign S_AXI_ARREADY_O = !s_q.rvalid;
  assign S_AXI_RVALID_O = s_q.rvalid;
  assign S_AXI_RDATA_O = s_q.rdata;
  assign S_AXI_RRESP_O = s_q.rresp;
  assign CONV_INPUT_O = s_q.conv_input;
  assign CONV_TRIGGER_O = s_q.trig;
  // Inactive level follows the polarity bit, so low-active idles high
  assign SAMPLE_READY_FLAG_O = s_q.ready ~^ s_q.iface_ctrl[`AICS_IF_POL_BIT];
  assign FIFO_CLEAR_O = s_q.fifo_clr;
  assign INPUT_CTRL_O = s_q.input_ctrl;
  assign IFACE_CTRL_O = s_q.iface_ctrl;
  assign IRQ_O = s_q.irq;
endmodule

// >>> design/aics_defines.svh
// Register offsets, field positions, reset values and counts for the input channel select block
`ifndef AICS_DEFINES_SVH
`define AICS_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define AICS_ADDR_INPUT_CTRL 8'h00
`define AICS_ADDR_IFACE_CTRL 8'h04
`define AICS_ADDR_IRQ_STATUS 8'h08
`define AICS_ADDR_IRQ_MASK 8'h0C
`define AICS_ADDR_SEQ_STATUS 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AICS_SEL_LSB 3
`define AICS_SEL_MSB 7
`define AICS_TEST_LSB 8
`define AICS_TEST_MSB 9
`define AICS_IF_RESET_BIT 0
`define AICS_IF_OVFL_BIT 1
`define AICS_IF_PULSE_BIT 4
`define AICS_IF_POL_BIT 5
`define AICS_IRQ_RESERVED_BIT 0
`define AICS_IRQ_OVFL_BIT 1
`define AICS_IRQ_WRAP_BIT 2

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define AICS_INPUT_CTRL_RST 10'h020
`define AICS_IFACE_CTRL_RST 10'h030
`define AICS_IRQ_W 3
`define AICS_SYNC_STAGES 2

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define AICS_RESP_OKAY 2'h0
`define AICS_RESP_SLVERR 2'h2

`endif

// >>> design/aics_pkg.sv
// Types shared by the input channel select block
package aics_pkg;

  // Converter input routing, including the internal reference levels
  typedef enum logic [3:0] {
    AICS_IN_A_PLUS = 4'h0,
    AICS_IN_A_MINUS = 4'h1,
    AICS_IN_B_PLUS = 4'h2,
    AICS_IN_B_MINUS = 4'h3,
    AICS_IN_DIFF_A = 4'h4,
    AICS_IN_DIFF_B = 4'h5,
    AICS_IN_REF_UPPER = 4'h6,
    AICS_IN_REF_MID = 4'h7,
    AICS_IN_REF_LOWER = 4'h8
  } aics_input_type;

  // Pin synchroniser state
  typedef struct packed {
    logic [1:0] stage;
    logic prev;
    logic fall;
  } aics_sync_state_type;

  // Channel sequencer state
  typedef struct packed {
    logic [1:0] pos;
    aics_input_type cur;
    logic wrap;
  } aics_seq_state_type;

  // Top level state: registers, bus slave and output stage
  typedef struct packed {
    logic [9:0] input_ctrl;
    logic [9:0] iface_ctrl;
    logic ovfl;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic fifo_clr;
    logic restart;
    logic trig;
    logic ready;
    logic fill_prev;
    aics_input_type conv_input;
    logic irq;
  } aics_top_state_type;

endpackage

// >>> design/aics_pin_sync.sv
// Two-flop pin synchroniser with falling edge detector
`timescale 1ns/10ps
`include "aics_defines.svh"
module aics_pin_sync #(
  parameter int STAGES = `AICS_SYNC_STAGES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o,
  output logic fall_o
);
  aics_pkg::aics_sync_state_type s_q;
  aics_pkg::aics_sync_state_type s_d;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (STAGES != 2) begin : g_bad_stages
    $error("aics_pin_sync supports exactly two stages");
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Stage 0 feeds only stage 1; the edge detector looks at stage 1
  always_comb begin
    s_d = s_q;
    s_d.stage = {s_q.stage[0], pin_i};
    s_d.prev = s_q.stage[1];
    s_d.fall = s_q.prev & ~s_q.stage[1];
  end

  // Registered state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_o = s_q.stage[1];
  assign fall_o = s_q.fall;
endmodule

// >>> design/aics_scan_seq.sv
// Channel sequencer: decodes the selection field and steps through autoscan orders
`timescale 1ns/10ps
module aics_scan_seq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] sel_i,
  input wire logic restart_i,
  input wire logic advance_i,
  output aics_pkg::aics_input_type input_o,
  output logic wrap_o,
  output logic reserved_o
);
  aics_pkg::aics_seq_state_type s_q;
  aics_pkg::aics_seq_state_type s_d;
  logic [2:0] len;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Sequence length per code; zero marks a reserved code
  function automatic logic [2:0] seq_len(input logic [4:0] sel);
    unique case (sel)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05: seq_len = 3'h1;
      5'h11, 5'h15, 5'h19: seq_len = 3'h2;
      5'h12, 5'h16: seq_len = 3'h3;
      5'h13: seq_len = 3'h4;
      default: seq_len = 3'h0;
    endcase
  endfunction

  // Input routed at a given sequence position
  function automatic aics_pkg::aics_input_type pick(input logic [4:0] sel,
                                                    input logic [1:0] pos);
    pick = aics_pkg::AICS_IN_A_PLUS;
    if (sel[4] == 1'b0) begin
      // Single input: single-ended by pick pair, or one pair difference
      pick = sel[2] ? aics_pkg::aics_input_type'({3'h2, sel[0]})
                    : aics_pkg::aics_input_type'({2'h0, sel[1:0]});
    end else if (sel[3:2] == 2'h0) begin
      pick = aics_pkg::aics_input_type'({2'h0, pos});
    end else if (sel == 5'h15) begin
      pick = pos[0] ? aics_pkg::AICS_IN_DIFF_B : aics_pkg::AICS_IN_A_PLUS;
    end else if (sel == 5'h16) begin
      pick = (pos == 2'h2) ? aics_pkg::AICS_IN_DIFF_B
                           : aics_pkg::aics_input_type'({2'h0, pos});
    end else if (sel == 5'h19) begin
      pick = pos[0] ? aics_pkg::AICS_IN_DIFF_B : aics_pkg::AICS_IN_DIFF_A;
    end
  endfunction

  assign len = seq_len(sel_i);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Rewrite restarts at position zero; each trigger steps once
  always_comb begin
    s_d = s_q;
    s_d.wrap = 1'b0;
    if (restart_i || len == 3'h0) begin
      s_d.pos = 2'h0;
    end else if (advance_i) begin
      if ({1'b0, s_q.pos} + 3'h1 >= len) begin
        s_d.pos = 2'h0;
        s_d.wrap = (len > 3'h1);
      end else begin
        s_d.pos = s_q.pos + 2'h1;
      end
    end
    s_d.cur = pick(sel_i, s_d.pos);
  end

  // Registered state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Route follows the reset selection, so no stray channel shows after reset
      s_q <= '0;
      s_q.cur <= pick(sel_i, 2'h0);
    end else begin
      s_q <= s_d;
    end
  end

  assign input_o = s_q.cur;
  assign wrap_o = s_q.wrap;
  assign reserved_o = (len == 3'h0);
endmodule

// >>> tb/aics_conv_src.sv
// Conversion clock source standing in for the far side of the conversion pin
`timescale 1ns/10ps
module aics_conv_src (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fire_i,
  output logic pin_o
);
  // ----------------------------------------
  // Pulse shaper
  // ----------------------------------------
  logic [2:0] cnt_q;

  // One high pulse per request; the pin rests low between conversions
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 3'h0;
    end else if (fire_i && cnt_q == 3'h0) begin
      cnt_q <= 3'h4;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end

  // Falling edge comes three cycles after the request
  assign pin_o = (cnt_q > 3'h1);
endmodule

// >>> tb/aics_top_asserts.sv
// Concurrent checks on the ports of the input channel select block
`timescale 1ns/10ps
module aics_top_chk (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [3:0] CONV_INPUT_O,
  input wire logic CONV_TRIGGER_O,
  input wire logic SAMPLE_READY_FLAG_O,
  input wire logic FIFO_CLEAR_O,
  input wire logic [9:0] INPUT_CTRL_O,
  input wire logic [9:0] IFACE_CTRL_O
);
  // ----------------------------------------
  // Helpers and defaults
  // ----------------------------------------
  logic tst;
  logic [6:0] sel_hi;
  assign tst = |INPUT_CTRL_O[9:8];
  assign sel_hi = INPUT_CTRL_O[9:3];
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);

  property p_trig_pulse;
    CONV_TRIGGER_O |=> !CONV_TRIGGER_O;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger too long");
  property p_clr_pulse;
    FIFO_CLEAR_O |=> !FIFO_CLEAR_O;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("fifo clear too long");
  // Reference routing settles one cycle after the test field changes
  property p_test_route;
    tst && $stable(INPUT_CTRL_O[9:8]) |-> CONV_INPUT_O == 4'h5 + {2'h0, INPUT_CTRL_O[9:8]};
  endproperty
  a_test_route: assert property (p_test_route) else $error("bad test routing");
  property p_ready_quiet;
    tst && $past(tst) && $stable(IFACE_CTRL_O[5]) |-> SAMPLE_READY_FLAG_O == !IFACE_CTRL_O[5];
  endproperty
  a_ready_quiet: assert property (p_ready_quiet) else $error("ready in test mode");
  // Two settled cycles allow for the sequencer and output register lag
  property p_diff_hold;
    sel_hi == 7'h04 && $past(sel_hi) == 7'h04 && $past(sel_hi, 2) == 7'h04 |->
      CONV_INPUT_O == 4'h4;
  endproperty
  a_diff_hold: assert property (p_diff_hold) else $error("pair A not routed");
  property p_rd_lat;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_rd_hold;
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
  property p_wr_lat;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O |=>
      ##1 S_AXI_BVALID_O;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
endmodule

bind aics_top aics_top_chk u_chk (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
  .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
  .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
  .S_AXI_RREADY_I(S_AXI_RREADY_I), .S_AXI_RDATA_O(S_AXI_RDATA_O),
  .CONV_INPUT_O(CONV_INPUT_O), .CONV_TRIGGER_O(CONV_TRIGGER_O),
  .SAMPLE_READY_FLAG_O(SAMPLE_READY_FLAG_O), .FIFO_CLEAR_O(FIFO_CLEAR_O),
  .INPUT_CTRL_O(INPUT_CTRL_O), .IFACE_CTRL_O(IFACE_CTRL_O));

// >>> tb/tb.sv
// Self-checking bench for the input channel select block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb;
  // ----------------------------------------
  // Signals and tables
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic fill = 1'b0, ovfl = 1'b0, fire = 1'b0, conv_pin;
  logic awready, wready, bvalid, arready, rvalid, conv_trig, rdy_flag, fifo_clr, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [3:0] conv_in;
  logic [9:0] in_ctrl, if_ctrl;
  int error_cnt = 0, cmp_count = 0, cyc = 0, clr_seen = 0;
  // Only the documented selection codes are driven
  logic [4:0] sel_tab [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
    5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h19};
  logic [15:0] seq_tab [12] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5,
    16'h10, 16'h210, 16'h3210, 16'h50, 16'h510, 16'h54};
  int len_tab [12] = '{1, 1, 1, 1, 1, 1, 2, 3, 4, 2, 3, 2};

  always #10 clk = ~clk;

  aics_top uut (.REF_CLK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
    .S_AXI_RREADY_I(rready), .CONVERSION_CLOCK_PIN_I(conv_pin),
    .FILL_LEVEL_REACHED_I(fill), .FIFO_OVERFLOW_I(ovfl), .CONV_INPUT_O(conv_in),
    .CONV_TRIGGER_O(conv_trig), .SAMPLE_READY_FLAG_O(rdy_flag), .FIFO_CLEAR_O(fifo_clr),
    .INPUT_CTRL_O(in_ctrl), .IFACE_CTRL_O(if_ctrl), .IRQ_O(irq));

  aics_conv_src u_src (.clk_i(clk), .rst_i(rst), .fire_i(fire), .pin_o(conv_pin));

  // Watchdog and clear pulse counter; the ceiling is far above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (fifo_clr) clr_seen <= clr_seen + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Bus and pin tasks
  // ----------------------------------------
  // Response ready is raised late so the slave must hold its answer a cycle
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (1) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    bready <= 1'b0;
    resp = bresp;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    while (1) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    rready <= 1'b0;
    resp = rresp;
    rd = rdata;
  endtask

  task automatic conv_step();
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (20) begin
      @(negedge clk);
      if (conv_trig) break;
    end
    `CHK("trigger", 1'b1, conv_trig)
    // Route register follows the trigger by one cycle
    @(negedge clk);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_reset();
    `CHK("route_rst", 4'h4, conv_in)
    `CHK("ctrl0_pin", 10'h020, in_ctrl)
    axi_rd(8'h00);
    `CHK("ctrl0_rst", 32'h20, rd)
    axi_rd(8'h04);
    `CHK("ctrl1_rst", 32'h30, rd)
    axi_rd(8'h20);
    `CHK("unmapped", 2'h2, resp)
    axi_rd(8'h10);
    `CHK("seq_status", 32'h04, rd)
    axi_wr(8'h24, 32'h0);
    `CHK("wr_unmapped", 2'h2, resp)
  endtask

  // Every code, a full lap plus wrap, then a rewrite mid-sequence
  task automatic sc_select();
    int n;
    for (int i = 0; i < 12; i++) begin
      axi_wr(8'h00, {24'h0, sel_tab[i], 3'h0});
      settle();
      `CHK("first", seq_tab[i][3:0], conv_in)
      for (int k = 1; k <= len_tab[i]; k++) begin
        conv_step();
        n = k % len_tab[i];
        `CHK("step", seq_tab[i][n*4 +: 4], conv_in)
      end
      // One more step leaves scan codes off their first position
      conv_step();
      axi_wr(8'h00, {24'h0, sel_tab[i], 3'h0});
      settle();
      `CHK("restart", seq_tab[i][3:0], conv_in)
    end
  endtask

  task automatic sc_test();
    for (int t = 1; t < 4; t++) begin
      axi_wr(8'h00, {22'h0, 2'(t), 8'h20});
      settle();
      `CHK("test_route", 4'h5 + 4'(t), conv_in)
      @(posedge clk);
      fill <= 1'b1;
      repeat (4) begin
        @(negedge clk);
        `CHK("ready_off", 1'b0, rdy_flag)
      end
      @(posedge clk);
      fill <= 1'b0;
      axi_wr(8'h04, 32'h1);
      settle();
      `CHK("test_exit", 4'h4, conv_in)
    end
  endtask

  task automatic sc_iface();
    int c0;
    // Soft resets of earlier scenarios have pulsed the clear already
    c0 = clr_seen;
    axi_wr(8'h04, 32'h3FE);
    `CHK("wr_resp", 2'h0, resp)
    `CHK("ctrl1_pin", 10'h3FC, if_ctrl)
    axi_rd(8'h04);
    `CHK("ctrl1_rw", 32'h3FC, rd)
    `CHK("fifo_clr", c0 + 1, clr_seen)
    @(posedge clk);
    ovfl <= 1'b1;
    @(posedge clk);
    ovfl <= 1'b0;
    axi_rd(8'h04);
    `CHK("ovfl_set", 32'h3FE, rd)
    axi_rd(8'h04);
    `CHK("ovfl_clr", 32'h3FC, rd)
    fill <= 1'b1;
    repeat (4) begin
      @(negedge clk);
      if (rdy_flag) break;
    end
    `CHK("ready_pulse", 1'b1, rdy_flag)
    axi_wr(8'h08, 32'h7);
    axi_wr(8'h0C, 32'h2);
    fill <= 1'b0;
    settle();
    `CHK("irq_idle", 1'b0, irq)
    @(posedge clk);
    ovfl <= 1'b1;
    @(posedge clk);
    ovfl <= 1'b0;
    settle();
    `CHK("irq_set", 1'b1, irq)
    axi_wr(8'h08, 32'h2);
    settle();
    `CHK("irq_clr", 1'b0, irq)
    axi_wr(8'h0C, 32'h0);
    ovfl <= 1'b1;
    @(posedge clk);
    ovfl <= 1'b0;
    settle();
    `CHK("irq_mask", 1'b0, irq)
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence: eight reset cycles, then each scenario in turn
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    settle();
    sc_reset();
    sc_select();
    sc_test();
    sc_iface();
    finish_test();
  end
endmodule
